/* hdl/aicc_input_ctrl.sv */
`timescale 1ns/1ns
// How it works
// - Config 00 gives eight single-ended channels
// - Config bit1 only gives four differential pairs
// - Bit0 only: pseudo pairs; both: seven pseudo
// - Seven-input mode references channel seven
// - Sequence bits are stored; channel field always picks the channel
// - Sequence bits zero: host picks any channel
// - Each write picks next channel, no stepping
// - Span of one or two references, all modes
// - Full swing maps to 4096 or 1024 codes
// - Span bit zero single, one double
// - Output straight binary or twos complement
module aicc_input_ctrl
   import aicc_pkg::*;
#(
   parameter int RES_BITS = RES_BITS_DEF           // Converter resolution
) (
   input  wire logic                clk,            // 10 MHz system clock
   input  wire logic                resetn,         // Synchronous, active low
   input  wire logic [ADDR_W-1:0]   reg_addr,       // Register address
   input  wire logic [DATA_W-1:0]   reg_wdata,      // Register write data
   input  wire logic                reg_wr,         // Write strobe
   input  wire logic                reg_rd,         // Read strobe
   output      logic [DATA_W-1:0]   reg_rdata,      // Read data, cycle after strobe
   input  wire logic                sample_trigger, // Falling edge starts a sample
   output      logic                conv_start,     // One-cycle start to the core
   output      logic                conv_busy,      // Conversion in progress
   input  wire logic                raw_valid,      // Core result strobe
   input  wire logic [RES_BITS-1:0] raw_code,       // Core straight binary code
   output      aicc_sel_t           front_sel,      // Mux and span selection
   output      logic [RES_BITS-1:0] result,         // Formatted result
   output      logic                result_valid    // One-cycle result strobe
);

   // =============================================================
   // Elaboration check
   // =============================================================
   // Only the two documented variants have a defined code map
   if (RES_BITS != RES_BITS_DEF && RES_BITS != RES_BITS_ALT) begin : g_bad_res
      $error("RES_BITS must be 10 or 12");
   end

   typedef enum logic {ST_IDLE, ST_CONV} aicc_state_t;

   // =============================================================
   // Register state
   // =============================================================
   aicc_ctrl_t          ctrl_q, ctrl_d;     // Control register
   logic [DATA_W-1:0]   rdata_q, rdata_d;   // Read data holding flop
   logic                ctrl_wr;            // Control write this cycle
   // Read back over the register port, so declared ahead of the read mux
   aicc_sel_t           sel_q, sel_d;       // Selection frozen for a sample
   logic [RES_BITS-1:0] res_q, res_d;       // Formatted result

   // Control write decode and read mux
   always_comb begin
      ctrl_wr = reg_wr && (reg_addr == CTRL_OFS);
      ctrl_d  = ctrl_q;
      rdata_d = '0;
      // Each write fully replaces the fields, nothing steps on its own
      if (ctrl_wr) begin
         ctrl_d = aicc_ctrl_t'(reg_wdata[$bits(aicc_ctrl_t)-1:0]);
      end
      if (reg_rd) begin
         case (reg_addr)
            CTRL_OFS: rdata_d = DATA_W'(ctrl_q);
            STAT_OFS: rdata_d = DATA_W'({conv_busy, sel_q});
            RSLT_OFS: rdata_d = DATA_W'(res_q);
            // Unmapped addresses read as zero
            default:  rdata_d = '0;
         endcase
      end
   end

   // Register the control word and read data
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ctrl_q  <= CTRL_RST;
         rdata_q <= '0;
      end else begin
         ctrl_q  <= ctrl_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // =============================================================
   // Channel mapping
   // =============================================================
   aicc_sel_t new_sel;  // Selection the current control word asks for

   // Decode arrangement and channel field into mux settings.
   // The sequencer modes are outside this block; with any sequence
   // bit set the address field is still used so the mux never floats.
   always_comb begin
      new_sel.span2 = ctrl_q.span2;
      new_sel.twos  = ctrl_q.coding;
      case (ctrl_q.cfg)
         CFG_SINGLE: begin
            new_sel.pos     = ctrl_q.chan;
            new_sel.neg     = 3'h0;
            new_sel.neg_gnd = 1'b1;
         end
         CFG_DIFF4, CFG_PSEUDO4: begin
            // Pair index from the upper bits, low bit swaps polarity
            new_sel.pos     = ctrl_q.chan;
            new_sel.neg     = {ctrl_q.chan[2:1], ~ctrl_q.chan[0]};
            new_sel.neg_gnd = 1'b0;
         end
         CFG_PSEUDO7: begin
            new_sel.pos     = ctrl_q.chan;
            new_sel.neg     = COMMON_REF_CH;
            new_sel.neg_gnd = 1'b0;
         end
         default: begin
            new_sel.pos     = ctrl_q.chan;
            new_sel.neg     = 3'h0;
            new_sel.neg_gnd = 1'b1;
         end
      endcase
   end

   // =============================================================
   // Conversion control
   // =============================================================
   aicc_state_t         state_q, state_d;   // Idle or converting
   logic                trig_q;             // Trigger level last cycle
   logic                rv_q, rv_d;         // Result strobe
   logic                trig_fall;          // Falling edge seen

   // Start on a falling trigger edge while idle; edges during a
   // conversion are ignored so a sample is never cut short.
   always_comb begin
      trig_fall = trig_q && !sample_trigger;
      state_d   = state_q;
      sel_d     = sel_q;
      res_d     = res_q;
      rv_d      = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (trig_fall) begin
               sel_d   = new_sel;
               state_d = ST_CONV;
            end
         end
         ST_CONV: begin
            // Selection stays put even if the host writes meanwhile
            if (raw_valid) begin
               // Twos complement is the binary code with the MSB flipped
               res_d   = sel_q.twos ? {~raw_code[RES_BITS-1], raw_code[RES_BITS-2:0]}
                                    : raw_code;
               rv_d    = 1'b1;
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // Register conversion state
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_q <= ST_IDLE;
         sel_q   <= SEL_RST;
         trig_q  <= 1'b1;
         res_q   <= '0;
         rv_q    <= 1'b0;
      end else begin
         state_q <= state_d;
         sel_q   <= sel_d;
         trig_q  <= sample_trigger;
         res_q   <= res_d;
         rv_q    <= rv_d;
      end
   end

   assign conv_start   = trig_fall && (state_q == ST_IDLE);
   assign conv_busy    = (state_q == ST_CONV);
   assign front_sel    = sel_q;
   assign result       = res_q;
   assign result_valid = rv_q;

   // =============================================================
   // Assertions
   // =============================================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   se_map_a: assert property (conv_start && ctrl_q.cfg == CFG_SINGLE |=>
      sel_q.neg_gnd && sel_q.pos == $past(ctrl_q.chan))
      else $error("single-ended selection wrong");

   diff_map_a: assert property (conv_start && ctrl_q.cfg == CFG_DIFF4 |=>
      !sel_q.neg_gnd && sel_q.neg == {sel_q.pos[2:1], ~sel_q.pos[0]})
      else $error("differential pair wrong");

   pseudo_pair_a: assert property (conv_start && ctrl_q.cfg == CFG_PSEUDO4 |=>
      !sel_q.neg_gnd && sel_q.pos[2:1] == sel_q.neg[2:1])
      else $error("pseudo pair wrong");

   common_ref_a: assert property (conv_start && ctrl_q.cfg == CFG_PSEUDO7 |=>
      sel_q.neg == COMMON_REF_CH && !sel_q.neg_gnd)
      else $error("common reference not used");

   any_chan_a: assert property (conv_start && !ctrl_q.seq_en && !ctrl_q.seq_src
      |=> sel_q.pos == $past(ctrl_q.chan))
      else $error("host channel not taken");

   write_next_a: assert property (ctrl_wr ##1 conv_start |=>
      sel_q.pos == $past(reg_wdata[2:0], 2))
      else $error("write did not pick next channel");

   span_code_a: assert property (conv_start |=>
      sel_q.span2 == $past(ctrl_q.span2) && sel_q.twos == $past(ctrl_q.coding))
      else $error("span or coding not captured");

   fmt_a: assert property (conv_busy && raw_valid |=> result_valid &&
      result == ($past(sel_q.twos) ? ($past(raw_code) ^ {1'b1, {(RES_BITS-1){1'b0}}})
                                   : $past(raw_code)))
      else $error("result format wrong");

   hold_sel_a: assert property (conv_busy |=> $stable(sel_q))
      else $error("selection moved during conversion");

   diff_conv_c:   cover property (conv_start && ctrl_q.cfg == CFG_DIFF4 ##[1:20] result_valid);
   pseudo7_c:     cover property (conv_start && ctrl_q.cfg == CFG_PSEUDO7);
   write_start_c: cover property (ctrl_wr ##1 conv_start);

endmodule : aicc_input_ctrl

/* hdl/aicc_pkg.sv */
// =============================================================
// Shared constants and types for the input configuration block
// =============================================================
package aicc_pkg;

   // =============================================================
   // Register port
   // =============================================================
   localparam int          ADDR_W   = 4;      // Register address width
   localparam int          DATA_W   = 16;     // Register data width
   localparam logic [3:0]  CTRL_OFS = 4'h0;   // Control register
   localparam logic [3:0]  STAT_OFS = 4'h1;   // Last selection status
   localparam logic [3:0]  RSLT_OFS = 4'h2;   // Last formatted result

   // =============================================================
   // Converter figures
   // =============================================================
   localparam int          RES_BITS_DEF  = 12;    // 12-bit variant, 4096 codes
   localparam int          RES_BITS_ALT  = 10;    // 10-bit variant, 1024 codes
   localparam logic [2:0]  COMMON_REF_CH = 3'h7;  // Shared negative input

   // Input arrangement, coded as {input_config_bit1, input_config_bit0}
   typedef enum logic [1:0] {
      CFG_SINGLE  = 2'b00,  // Eight single-ended channels
      CFG_PSEUDO4 = 2'b01,  // Four pseudo differential pairs
      CFG_DIFF4   = 2'b10,  // Four fully differential pairs
      CFG_PSEUDO7 = 2'b11   // Seven inputs against the common reference
   } aicc_cfg_t;

   // Control register layout, bit 0 at the bottom
   typedef struct packed {
      logic       coding;        // [8] 1 = twos complement output
      logic       span2;         // [7] 1 = zero to twice reference
      logic       seq_src;       // [6] sequence_source_bit
      logic       seq_en;        // [5] sequence_enable_bit
      aicc_cfg_t  cfg;           // [4:3] input_config_bit1/bit0
      logic [2:0] chan;          // [2:0] channel_select_msb..lsb
   } aicc_ctrl_t;

   localparam aicc_ctrl_t CTRL_RST = '{coding: 1'b0, span2: 1'b0, seq_src: 1'b0,
                                       seq_en: 1'b0, cfg: CFG_SINGLE, chan: 3'h0};

   // Front-end selection held for one conversion
   typedef struct packed {
      logic [2:0] pos;           // Positive input channel
      logic [2:0] neg;           // Negative input channel
      logic       neg_gnd;       // Negative side tied to analog ground
      logic       span2;         // Doubled input span
      logic       twos;          // Twos complement coding
   } aicc_sel_t;

   localparam aicc_sel_t SEL_RST = '{pos: 3'h0, neg: 3'h0, neg_gnd: 1'b1,
                                     span2: 1'b0, twos: 1'b0};

endpackage : aicc_pkg

/* verification/aicc_core_model.sv */
`timescale 1ns/1ns
// =============================================================
// Converter core stand-in: answers each start after lat cycles
// =============================================================
module aicc_core_model
   import aicc_pkg::*;
#(
   parameter int RES_BITS = RES_BITS_DEF        // Code width
) (
   input  wire logic                clk,        // System clock
   input  wire logic                resetn,     // Synchronous, active low
   input  wire logic                conv_start, // Start from the block
   input  wire logic [3:0]          lat,        // Answer delay, 1 or more cycles
   input  wire logic [RES_BITS-1:0] code_in,    // Code the bench wants returned
   output      logic                raw_valid,  // One-cycle result strobe
   output      logic [RES_BITS-1:0] raw_code    // Straight binary code
);
   logic [3:0] cnt_q;  // Cycles left, zero when idle

   // Load on each start, then count down to the strobe
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cnt_q <= 4'h0;
      end else if (conv_start) begin
         cnt_q <= lat;
      end else if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
      end
   end

   assign raw_valid = (cnt_q == 4'h1);
   // Inverted outside the strobe, so a stale capture cannot match by luck
   assign raw_code  = raw_valid ? code_in : ~code_in;
endmodule : aicc_core_model

/* verification/test_aicc_input_ctrl.sv */
`timescale 1ns/1ns
module test_aicc_input_ctrl import aicc_pkg::*;;
   // =============================================================
   // Stimulus and observed signals
   // =============================================================
   logic        clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, trig = 1'b1;
   logic [3:0]  reg_addr = 4'h0, lat = 4'h1;  // Address, core answer delay
   logic [15:0] reg_wdata = 16'h0, reg_rdata;
   logic        conv_start, conv_busy, raw_valid, result_valid;
   logic [11:0] code = 12'h0, raw_code, result;
   aicc_sel_t   front_sel;
   aicc_ctrl_t  ctl, ctl2;                    // Control words in use
   int          num_errors = 0, checks = 0, starts = 0;

   initial forever #50 clk = ~clk;
   // Count starts to catch extra or missing ones
   always @(posedge clk) if (conv_start === 1'b1) starts <= starts + 1;

   aicc_input_ctrl #(.RES_BITS(12)) dut_u (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sample_trigger(trig), .conv_start(conv_start), .conv_busy(conv_busy),
      .raw_valid(raw_valid), .raw_code(raw_code), .front_sel(front_sel), .result(result),
      .result_valid(result_valid));
   aicc_core_model #(.RES_BITS(12)) core_u (.clk(clk), .resetn(resetn),
      .conv_start(conv_start), .lat(lat), .code_in(code), .raw_valid(raw_valid),
      .raw_code(raw_code));

   // =============================================================
   // Shared tasks
   // =============================================================
   task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge clk); reg_wr <= 1'b0;
   endtask : wr
   // Data stand only in the cycle after the strobe
   task rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk); reg_addr <= a; reg_rd <= 1'b1;
      @(posedge clk); reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp, "read data");
   endtask : rd
   function automatic aicc_sel_t exp_sel(input aicc_ctrl_t c);
      aicc_sel_t s;
      s.pos     = c.chan;
      s.neg_gnd = (c.cfg == CFG_SINGLE);
      s.neg     = (c.cfg == CFG_PSEUDO7) ? COMMON_REF_CH : {c.chan[2:1], ~c.chan[0]};
      s.span2   = c.span2;
      s.twos    = c.coding;
      return s;
   endfunction : exp_sel
   // Negative channel is don't-care while tied to ground
   task sel_chk(input aicc_sel_t e);
      aicc_sel_t g;
      g = front_sel;
      if (e.neg_gnd) g.neg = e.neg;
      chk({7'h0, g}, {7'h0, e}, "front selection");
   endtask : sel_chk
   // Start pulse is looked at while it stands, one step after the launching edge
   task start(input aicc_sel_t e, input logic [11:0] c, input logic [3:0] l);
      @(posedge clk); trig <= 1'b0; code <= c; lat <= l;
      #1 chk({15'h0, conv_start}, 16'h1, "start pulse");
      @(posedge clk);
      #1 sel_chk(e);
      chk({15'h0, conv_busy}, 16'h1, "busy");
   endtask : start
   task finish(input aicc_sel_t e, input logic [11:0] c);
      int n;
      n = 0;
      do begin @(posedge clk); #1 n++; end while (result_valid !== 1'b1 && n < 20);
      // A missing strobe counts here, so a hang cannot slip through
      chk({15'h0, result_valid}, 16'h1, "result strobe");
      chk({4'h0, result}, {4'h0, e.twos ? {~c[11], c[10:0]} : c}, "result");
      chk({15'h0, conv_busy}, 16'h0, "busy end");
      sel_chk(e);
      @(posedge clk); trig <= 1'b1;
      #1 chk({15'h0, result_valid}, 16'h0, "valid pulse");
   endtask : finish
   task print_verdict;
      $display("Counts: %0d checks, %0d errors", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : print_verdict

   initial begin #200000; num_errors++; print_verdict(); end

   // =============================================================
   // Tests
   // =============================================================
   initial begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      rd(CTRL_OFS, 16'h0);
      rd(STAT_OFS, {7'h0, SEL_RST});
      rd(RSLT_OFS, 16'h0);
      rd(4'h5, 16'h0);
      $display("Test reset values finished");
      // Every arrangement, both spans, both codings, varied latency
      for (int i = 0; i < 8; i++) begin
         ctl = '{coding: i[0] ^ i[2], span2: i[2], seq_src: 1'b0, seq_en: 1'b0,
                 cfg: aicc_cfg_t'(i[1:0]), chan: 3'(i * 3)};
         wr(CTRL_OFS, 16'hfe00 | {7'h0, ctl});
         rd(CTRL_OFS, {7'h0, ctl});
         start(exp_sel(ctl), 12'h8c3 ^ 12'(i), 4'(1 + i));
         finish(exp_sel(ctl), 12'h8c3 ^ 12'(i));
      end
      $display("Test input arrangements finished");
      // No write between conversions: channel must not step
      repeat (2) begin
         start(exp_sel(ctl), 12'h07f, 4'h1);
         finish(exp_sel(ctl), 12'h07f);
      end
      $display("Test no stepping finished");
      // Write and a trigger fall while busy must not disturb the running one
      ctl2 = '{coding: 1'b0, span2: 1'b1, seq_src: 1'b0, seq_en: 1'b0, cfg: CFG_DIFF4,
               chan: 3'h2};
      start(exp_sel(ctl), 12'hfff, 4'h9);
      rd(STAT_OFS, {6'h0, 1'b1, exp_sel(ctl)});
      wr(CTRL_OFS, {7'h0, ctl2});
      @(posedge clk); trig <= 1'b1;
      @(posedge clk); trig <= 1'b0;
      finish(exp_sel(ctl), 12'hfff);
      start(exp_sel(ctl2), 12'h001, 4'h2);
      finish(exp_sel(ctl2), 12'h001);
      rd(RSLT_OFS, 16'h0001);
      // Write, then trigger in the very next cycle: the new channel is taken
      ctl = '{coding: 1'b1, span2: 1'b0, seq_src: 1'b0, seq_en: 1'b0, cfg: CFG_SINGLE,
              chan: 3'h6};
      wr(CTRL_OFS, {7'h0, ctl});
      trig <= 1'b0; code <= 12'h5a5; lat <= 4'h3;
      @(posedge clk);
      #1 sel_chk(exp_sel(ctl));
      finish(exp_sel(ctl), 12'h5a5);
      chk(16'(starts), 16'd13, "start count");
      $display("Test write during busy finished");
      print_verdict();
   end
endmodule : test_aicc_input_ctrl
